// file: hw/drcl_core.sv
// Contract
// - Keypad inching needs inch key and keypad source
// - Multi key toggles inching, icon shows it
// - Held direction key runs at inching frequency
// - Inching stops with no direction key
// - Inching uses own accel and decel times
// - Terminal codes 17,18,20 give up/down/clear
// - Raise input accelerates, release holds speed
// - Lower input decelerates, release holds speed
// - Both inputs on holds present speed
// - Save running frequency on stop, trip, power-fail
// - Resume from stored frequency on restart
// - Clear input erases stored frequency
// - Code 14 with source 1 latches push-buttons
// - Forward plus reverse together stops motor
// - Code 13 marks the run-enable input
// - Run-enable only honoured in input-gated mode
// - Stop option 0 cuts output, coasts
// - Stop option 1 quick-stops, needs new command
// - Quick-stop time applies only for options 1,2
// - Inching outranks every other speed source
`timescale 1ns/100ps
`default_nettype none
module drcl_core
  import drcl_pkg::*;
#(
  parameter int TERMS    = drcl_pkg::TERM_N,
  parameter int TICK_DIV = drcl_pkg::RAMP_DIV
) (
  input  wire logic                        mclk_i,          // Clock
  input  wire logic                        rst_i,           // Reset
  input  wire logic [1:0]                  multi_key_sel_i, // Multi key use
  input  wire logic [2:0]                  cmd_source_i,    // Command source
  input  wire logic [TERMS*drcl_pkg::FUNC_W-1:0] terminal_function_code_i, // Codes
  input  wire logic                        input_gated_i,   // Run-en mode
  input  wire logic [1:0]                  run_dis_stop_i,  // Stop option
  input  wire logic                        ud_save_i,       // Up/down save
  input  wire logic [drcl_pkg::FREQ_W-1:0] inch_freq_i,     // Inching freq
  input  wire logic [drcl_pkg::FREQ_W-1:0] max_freq_i,      // Max freq
  input  wire logic [drcl_pkg::FREQ_W-1:0] ud_step_i,       // Up/down step
  input  wire logic                        multi_key_i,     // Pin
  input  wire logic                        forward_key_i,   // Pin
  input  wire logic                        reverse_key_i,   // Pin
  input  wire logic                        forward_run_input_i, // Pin
  input  wire logic                        reverse_run_input_i, // Pin
  input  wire logic [TERMS-1:0]            terminal_i,      // Pins
  input  wire logic                        trip_i,          // Trip event
  input  wire logic                        power_fail_i,    // Power fail
  output logic                             inch_icon_o,     // Icon lit while armed
  output logic                             run_o,           // Output on
  output logic                             reverse_o,       // Direction
  output logic                             coast_o,         // Output cut
  output logic [drcl_pkg::FREQ_W-1:0]      target_freq_o,   // Reference
  output logic [drcl_pkg::FREQ_W-1:0]      ud_freq_o,       // Up/down freq
  output logic [drcl_pkg::FREQ_W-1:0]      saved_freq_o,    // Stored freq
  output var drcl_ramp_t                   ramp_sel_o       // Ramp in use
);
  import drcl_pkg::*;

  localparam int SYN_W = TERMS + 5;

  typedef struct packed
  {
    logic              inch_rdy;    // Keypad inching armed
    logic              mk_prev;     // Multi key last level
    logic              tw_run;      // Three-wire latched run
    logic              tw_rev;      // Three-wire direction
    logic              qs_lock;     // Quick-stop lock awaiting command
    logic              run;
    logic              reverse_key;
    logic              coast;
    logic [FREQ_W-1:0] ud_freq;     // Up/down frequency
    logic [FREQ_W-1:0] saved;       // Stored setpoint
    logic              saved_ok;
    logic [FREQ_W-1:0] target;
    drcl_ramp_t        ramp;
    logic [15:0]       tick_cnt;
    logic              was_run;
  } drcl_state_t;

  drcl_state_t st_q;
  drcl_state_t st_d;
  logic [SYN_W-1:0] syn;

  // Every pin is asynchronous to the core clock
  drcl_sync #(.W(SYN_W)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({multi_key_i, forward_key_i, reverse_key_i,
              forward_run_input_i, reverse_run_input_i, terminal_i}),
    .q_o    (syn)
  );

  wire logic mk_s  = syn[SYN_W-1];
  wire logic fk_s  = syn[SYN_W-2];
  wire logic rk_s  = syn[SYN_W-3];
  wire logic fx_s  = syn[SYN_W-4];
  wire logic rx_s  = syn[SYN_W-5];
  wire logic [TERMS-1:0] term_s = syn[TERMS-1:0];

  // Per-terminal function decode
  logic [TERMS-1:0] is_up;
  logic [TERMS-1:0] is_dn;
  logic [TERMS-1:0] is_clr;
  logic [TERMS-1:0] is_en;
  logic [TERMS-1:0] is_tw;
  logic [TERMS-1:0] en_cfg;
  genvar g;
  generate
    for (g = 0; g < TERMS; g++)
    begin : g_term
      wire logic [FUNC_W-1:0] fc = terminal_function_code_i[g*FUNC_W +: FUNC_W];
      assign is_up[g]  = term_s[g] && (fc == FN_SPEED_UP);
      assign is_dn[g]  = term_s[g] && (fc == FN_SPEED_DOWN);
      assign is_clr[g] = term_s[g] && (fc == FN_UD_CLEAR);
      assign en_cfg[g] = (fc == FN_RUN_ENABLE);
      assign is_en[g]  = term_s[g] && en_cfg[g];
      assign is_tw[g]  = term_s[g] && (fc == FN_THREE_WIRE);
    end
  endgenerate

  logic [TERMS-1:0] tw_cfg;
  generate
    for (g = 0; g < TERMS; g++)
    begin : g_twc
      assign tw_cfg[g] = terminal_function_code_i[g*FUNC_W +: FUNC_W]
                         == FN_THREE_WIRE;
    end
  endgenerate

  // Decoded conditions
  logic up_on;
  logic dn_on;
  logic clr_on;
  logic en_ok;
  logic inch_mode;
  logic tw_mode;
  logic term_run;
  logic term_rev;
  logic tick;
  logic [FREQ_W:0] up_sum;

  always_comb
  begin
    up_on     = |is_up;
    dn_on     = |is_dn;
    clr_on    = |is_clr;
    // Run-enable only counts in input-gated mode with a terminal assigned
    en_ok     = !(input_gated_i && (|en_cfg)) || (|is_en);
    inch_mode = (multi_key_sel_i == MULTI_KEY_INCH) &&
                (cmd_source_i == CMD_SRC_KEYPAD) && st_q.inch_rdy;
    tw_mode   = (cmd_source_i == CMD_SRC_TERM) && (|tw_cfg);
    tick      = (st_q.tick_cnt == 16'(TICK_DIV - 1));
    up_sum    = {1'b0, st_q.ud_freq} + {1'b0, ud_step_i};
    // Plain two-wire or latched three-wire command, both-on is a stop
    if (tw_mode)
    begin
      term_run = st_q.tw_run;
      term_rev = st_q.tw_rev;
    end
    else
    begin
      term_run = (fx_s ^ rx_s);
      term_rev = rx_s && !fx_s;
    end
  end

  // Next state
  always_comb
  begin
    st_d          = st_q;
    st_d.mk_prev  = mk_s;
    st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;
    // Each rising press of the multi key flips readiness
    if (mk_s && !st_q.mk_prev)
      st_d.inch_rdy = !st_q.inch_rdy;
    // Readiness only means something for keypad inching; dropping it
    // here also keeps the icon dark while terminals own the command
    if (multi_key_sel_i != MULTI_KEY_INCH ||
        cmd_source_i != CMD_SRC_KEYPAD)
      st_d.inch_rdy = 1'b0;

    // Three-wire: run buttons latch, stop terminal opening drops latch.
    // A short glitch is still latched; callers keep 1 ms pulses.
    if (tw_mode)
    begin
      if (!(|is_tw) || (fx_s && rx_s))
        st_d.tw_run = 1'b0;
      else if (fx_s ^ rx_s)
      begin
        st_d.tw_run = 1'b1;
        st_d.tw_rev = rx_s;
      end
    end
    else
      st_d.tw_run = 1'b0;

    // Up/down frequency, held when neither or both are on
    if (term_run && tick && !(up_on && dn_on))
    begin
      if (up_on)
        st_d.ud_freq = (up_sum > {1'b0, max_freq_i}) ? max_freq_i
                       : up_sum[FREQ_W-1:0];
      else if (dn_on)
        st_d.ud_freq = (st_q.ud_freq > ud_step_i)
                       ? st_q.ud_freq - ud_step_i : '0;
    end

    // Store at end of constant-speed running, trip or power failure
    if (ud_save_i && st_q.was_run && !up_on && !dn_on &&
        (!term_run || trip_i || power_fail_i))
    begin
      st_d.saved    = st_q.ud_freq;
      st_d.saved_ok = 1'b1;
    end
    // Resume from the stored value on a fresh command
    if (term_run && !st_q.was_run && st_q.saved_ok && ud_save_i)
      st_d.ud_freq = st_q.saved;
    // Clear only while stopped or at constant speed
    if (clr_on && (!term_run || (!up_on && !dn_on)))
    begin
      st_d.saved    = '0;
      st_d.saved_ok = 1'b0;
      st_d.ud_freq  = '0;
    end
    st_d.was_run = term_run && !trip_i && !power_fail_i;

    // Run-disable handling; the lock waits for the command to drop
    if (!en_ok && run_dis_stop_i == STOP_QSTOP)
      st_d.qs_lock = 1'b1;
    else if (!term_run)
      st_d.qs_lock = 1'b0;

    // Output selection, inching first
    st_d.coast = 1'b0;
    if (inch_mode)
    begin
      st_d.run    = fk_s ^ rk_s;
      st_d.reverse_key    = rk_s && !fk_s;
      st_d.target = (fk_s ^ rk_s) ? inch_freq_i : '0;
      st_d.ramp   = DRCL_RAMP_INCH;
    end
    else if (!en_ok)
    begin
      st_d.run    = 1'b0;
      st_d.target = '0;
      if (run_dis_stop_i == STOP_FREE_RUN)
      begin
        st_d.coast = 1'b1;
        st_d.ramp  = DRCL_RAMP_NORM;
      end
      else
        st_d.ramp  = DRCL_RAMP_QSTOP;
    end
    else if (st_q.qs_lock && run_dis_stop_i == STOP_QSTOP)
    begin
      st_d.run    = 1'b0;
      st_d.target = '0;
      st_d.ramp   = DRCL_RAMP_QSTOP;
    end
    else
    begin
      // Option 2 falls through here and restarts while command holds
      st_d.run    = term_run && !trip_i;
      st_d.reverse_key    = term_run ? term_rev : st_q.reverse_key;
      st_d.target = term_run ? st_q.ud_freq : '0;
      st_d.ramp   = DRCL_RAMP_NORM;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_q      <= '0;
      st_q.ramp <= DRCL_RAMP_NORM;
    end
    else
      st_q <= st_d;
  end

  assign inch_icon_o   = st_q.inch_rdy;
  assign run_o         = st_q.run;
  assign reverse_o     = st_q.reverse_key;
  assign coast_o       = st_q.coast;
  assign target_freq_o = st_q.target;
  assign ud_freq_o     = st_q.ud_freq;
  assign saved_freq_o  = st_q.saved;
  assign ramp_sel_o    = st_q.ramp;

  // Checks beside the logic
  a_inch_stop: assert property (@(posedge mclk_i)
    disable iff (rst_i) inch_mode && !fk_s && !rk_s |=> !run_o)
    else $error("Inching ran without a key");
  a_inch_ramp: assert property (@(posedge mclk_i)
    disable iff (rst_i) inch_mode |=> ramp_sel_o == DRCL_RAMP_INCH)
    else $error("Inching ramp not selected");
  a_ud_hold: assert property (@(posedge mclk_i)
    disable iff (rst_i) up_on && dn_on && !clr_on && st_q.was_run
    && term_run |=> $stable(ud_freq_o))
    else $error("Up/down moved with both inputs on");
  a_ud_clamp: assert property (@(posedge mclk_i)
    disable iff (rst_i) !clr_on && $changed(ud_freq_o) && $past(up_on)
    |-> ud_freq_o <= max_freq_i)
    else $error("Up/down frequency above maximum");
  a_coast_cut: assert property (@(posedge mclk_i)
    disable iff (rst_i) !inch_mode && !en_ok
    && run_dis_stop_i == STOP_FREE_RUN |=> coast_o && !run_o)
    else $error("Free-run stop did not cut output");
  a_qstop_ramp: assert property (@(posedge mclk_i)
    disable iff (rst_i) !inch_mode && !en_ok
    && run_dis_stop_i != STOP_FREE_RUN
    |=> ramp_sel_o == DRCL_RAMP_QSTOP && !coast_o)
    else $error("Quick-stop ramp not used");
  a_both_stop: assert property (@(posedge mclk_i)
    disable iff (rst_i) !inch_mode && !tw_mode && fx_s && rx_s |=> !run_o)
    else $error("Both directions did not stop");
  a_gate_off: assert property (@(posedge mclk_i)
    disable iff (rst_i) !input_gated_i && !inch_mode && !tw_mode && fx_s
    && !rx_s && !trip_i && !st_q.qs_lock |=> run_o)
    else $error("Run blocked with enable ignored");
  a_clear_save: assert property (@(posedge mclk_i)
    disable iff (rst_i) clr_on && !term_run |=> saved_freq_o == '0)
    else $error("Clear did not erase setpoint");

  // Icon, lock, direction and latch checks
  a_icon_avail: assert property (@(posedge mclk_i)
    disable iff (rst_i) cmd_source_i != CMD_SRC_KEYPAD |=> !inch_icon_o)
    else $error("Icon lit without keypad inching");
  a_lock_hold: assert property (@(posedge mclk_i)
    disable iff (rst_i) st_q.qs_lock && run_dis_stop_i == STOP_QSTOP
    && !inch_mode |=> !run_o)
    else $error("Quick-stop lock let the drive restart");
  a_inch_dir: assert property (@(posedge mclk_i)
    disable iff (rst_i) inch_mode && fk_s && !rk_s |=> run_o && !reverse_o)
    else $error("Forward inching key did not run forward");
  a_tw_stop: assert property (@(posedge mclk_i)
    disable iff (rst_i) tw_mode && !(|is_tw) |=> !st_q.tw_run)
    else $error("Open stop contact left the latch set");

  c_inch_run: cover property (@(posedge mclk_i) inch_mode && run_o);
  c_ud_both:  cover property (@(posedge mclk_i) up_on && dn_on && term_run);
  c_tw_latch: cover property (@(posedge mclk_i) tw_mode && st_q.tw_run);
  c_qs_lock:  cover property (@(posedge mclk_i) st_q.qs_lock && en_ok);
  c_ud_save:  cover property (@(posedge mclk_i) st_q.saved_ok);
endmodule : drcl_core
`default_nettype wire

// file: hw/drcl_pkg.sv
package drcl_pkg;

  // Frequency word width (units of 0.01 Hz)
  localparam int FREQ_W = 16;
  localparam int TERM_N = 11;          // Multi-function input terminals
  localparam int FUNC_W = 6;           // Terminal function code width

  // Terminal function codes
  localparam logic [FUNC_W-1:0] FN_RUN_ENABLE = 6'h0d;
  localparam logic [FUNC_W-1:0] FN_THREE_WIRE = 6'h0e;
  localparam logic [FUNC_W-1:0] FN_SPEED_UP   = 6'h11;
  localparam logic [FUNC_W-1:0] FN_SPEED_DOWN = 6'h12;
  localparam logic [FUNC_W-1:0] FN_UD_CLEAR   = 6'h14;

  // Configuration values
  localparam logic [1:0] MULTI_KEY_INCH = 2'h1;
  localparam logic [2:0] CMD_SRC_KEYPAD = 3'h0;
  localparam logic [2:0] CMD_SRC_TERM   = 3'h1;
  localparam logic [1:0] STOP_FREE_RUN  = 2'h0;
  localparam logic [1:0] STOP_QSTOP     = 2'h1;
  localparam logic [1:0] STOP_QRESUME   = 2'h2;

  // Minimum three-wire pulse and the tick period of the ramp
  localparam int MIN_PULSE_NS  = 1000000;   // 1 ms
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_PULSE_CYC = MIN_PULSE_NS / CLK_PERIOD_NS;
  localparam int RAMP_DIV      = 25000;     // 100 us ramp tick at 250 MHz
  localparam logic [FREQ_W-1:0] QSTOP_DEFAULT = 16'h0032; // 5.0 s in 0.1 s

  // Ramp selection
  typedef enum logic [2:0]
  {
    DRCL_RAMP_NORM  = 3'b001,
    DRCL_RAMP_INCH  = 3'b010,
    DRCL_RAMP_QSTOP = 3'b100
  } drcl_ramp_t;

endpackage : drcl_pkg

// file: hw/drcl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module drcl_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,  // Core clock
  input  wire logic         rst_i,   // Synchronous reset
  input  wire logic [W-1:0] d_i,     // Asynchronous inputs
  output logic      [W-1:0] q_o      // Synchronised outputs
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } drcl_sync_t;

  drcl_sync_t st_q;
  drcl_sync_t st_d;

  // Two stages; only the second stage is read outside
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q_o = st_q.s2;
endmodule : drcl_sync
`default_nettype wire

// file: test/drcl_switches.sv
`timescale 1ns/100ps
`default_nettype none
module drcl_switches #(
  parameter int TERMS = 11,
  parameter int HOLD  = 8
) (
  input  wire logic             mclk_i,  // Clock for pacing presses
  output logic      [4:0]       key_o,   // Keypad keys and run inputs
  output logic      [TERMS-1:0] term_o   // Terminal contacts
);
  // Open contacts read low, as the pins are active high
  initial
  begin
    key_o  = '0;
    term_o = '0;
  end

  // Levels change only just after a falling edge
  task automatic set_key(input logic [4:0] m, input logic v);
    @(negedge mclk_i);
    key_o = v ? (key_o | m) : (key_o & ~m);
  endtask : set_key

  task automatic set_term(input logic [TERMS-1:0] m, input logic v);
    @(negedge mclk_i);
    term_o = v ? (term_o | m) : (term_o & ~m);
  endtask : set_term

  // Momentary press; HOLD is scaled down so runs stay short
  task automatic pulse_key(input logic [4:0] m);
    set_key(m, 1'b1);
    repeat (HOLD) @(negedge mclk_i);
    key_o = key_o & ~m;
  endtask : pulse_key

  // Momentary opening of a normally closed contact
  task automatic pulse_term(input logic [TERMS-1:0] m);
    set_term(m, 1'b0);
    repeat (HOLD) @(negedge mclk_i);
    term_o = term_o | m;
  endtask : pulse_term
endmodule : drcl_switches
`default_nettype wire

// file: test/drcl_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fail_count++; $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module drcl_core_tb;
  import drcl_pkg::*;
  localparam int TD = 4;        // Short ramp tick keeps up/down runs brief
  localparam int TN = TERM_N;
  localparam logic [4:0] MK = 5'h01, FK = 5'h02, RK = 5'h04;
  localparam logic [4:0] FR = 5'h08, RR = 5'h10;
  logic                 mclk_i;
  logic                 rst_i;
  logic [1:0]           sel, stop_opt;
  logic [2:0]           src;
  logic [TN*FUNC_W-1:0] tfc;
  logic                 gated, ud_save, trip, pfail;
  logic [FREQ_W-1:0]    inch_f, max_f, step_f, target, ud, saved, v, r;
  logic                 icon, run, reverse_key, coast;
  drcl_ramp_t           ramp;
  logic [4:0]           keys;
  logic [TN-1:0]        term;
  logic [31:0]          seed;
  int                   fail_count, samples_checked;

  // Free-running core clock
  always #2 mclk_i = ~mclk_i;

  drcl_switches #(.TERMS(TN), .HOLD(6)) u_sw (
    .mclk_i (mclk_i),
    .key_o  (keys),
    .term_o (term)
  );

  drcl_core #(.TERMS(TN), .TICK_DIV(TD)) u_dut (
    .mclk_i                   (mclk_i),
    .rst_i                    (rst_i),
    .multi_key_sel_i          (sel),
    .cmd_source_i             (src),
    .terminal_function_code_i (tfc),
    .input_gated_i            (gated),
    .run_dis_stop_i           (stop_opt),
    .ud_save_i                (ud_save),
    .inch_freq_i              (inch_f),
    .max_freq_i               (max_f),
    .ud_step_i                (step_f),
    .multi_key_i              (keys[0]),
    .forward_key_i            (keys[1]),
    .reverse_key_i            (keys[2]),
    .forward_run_input_i      (keys[3]),
    .reverse_run_input_i      (keys[4]),
    .terminal_i               (term),
    .trip_i                   (trip),
    .power_fail_i             (pfail),
    .inch_icon_o              (icon),
    .run_o                    (run),
    .reverse_o                (reverse_key),
    .coast_o                  (coast),
    .target_freq_o            (target),
    .ud_freq_o                (ud),
    .saved_freq_o             (saved),
    .ramp_sel_o               (ramp)
  );

  // Fixed-seed xorshift so every run repeats
  function automatic logic [15:0] rnd16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd16

  // Covers 2 sync stages, the state update and some margin
  task automatic settle();
    repeat (6) @(negedge mclk_i);
  endtask : settle

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Bounded wait for the up/down frequency to reach a value
  task automatic wait_ud(input logic [FREQ_W-1:0] e);
    int n;
    n = 0;
    while (ud !== e && n < 5000)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 5000)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, ud, e);
      stop_test();
    end
  endtask : wait_ud

  initial
  begin
    mclk_i = 1'b0; rst_i = 1'b1; sel = 2'h0; src = 3'h0; tfc = '0;
    gated = 1'b0; stop_opt = 2'h0; ud_save = 1'b0; trip = 1'b0;
    pfail = 1'b0; inch_f = 16'h0000; max_f = 16'h0000; step_f = 16'h0001;
    seed = 32'h8f2e; fail_count = 0; samples_checked = 0;
    repeat (8) @(negedge mclk_i);
    `CHK(run, 1'b0)
    `CHK(ramp, DRCL_RAMP_NORM)
    rst_i = 1'b0;
    // Keypad inching; a held terminal run must not interfere
    src = CMD_SRC_KEYPAD; sel = MULTI_KEY_INCH; inch_f = rnd16() | 16'h0001;
    max_f = 16'hffff;
    u_sw.pulse_key(MK); settle();
    `CHK(icon, 1'b1)
    u_sw.set_key(FR | FK, 1'b1); settle();
    `CHK(run, 1'b1)
    `CHK(target, inch_f)
    `CHK(ramp, DRCL_RAMP_INCH)
    `CHK(reverse_key, 1'b0)
    u_sw.set_key(FK, 1'b0); settle();
    `CHK(run, 1'b0)
    `CHK(ramp, DRCL_RAMP_INCH)
    u_sw.set_key(RK, 1'b1); settle();
    `CHK({run, reverse_key}, 2'b11)
    u_sw.set_key(RK | FR, 1'b0);
    u_sw.pulse_key(MK); settle();
    `CHK(icon, 1'b0)
    sel = 2'h0; u_sw.pulse_key(MK); settle();
    `CHK(icon, 1'b0)
    src = CMD_SRC_TERM; sel = MULTI_KEY_INCH; u_sw.pulse_key(MK); settle();
    `CHK(icon, 1'b0)
    $display("test inching done");
    // Up/down with random step and ceiling; t0 up, t1 down, t2 clear
    sel = 2'h0; ud_save = 1'b1;
    tfc[0+:6] = FN_SPEED_UP; tfc[6+:6] = FN_SPEED_DOWN;
    tfc[12+:6] = FN_UD_CLEAR;
    for (int i = 0; i < 2; i++)
    begin
      r = rnd16();
      step_f = 16'(r[3:0]) + 16'h0001;
      max_f = 16'h0100 + 16'(r[11:4]);
      u_sw.set_key(FR, 1'b1); u_sw.set_term(11'h001, 1'b1);
      wait_ud(max_f);
      repeat (8 * TD) @(negedge mclk_i);
      `CHK(ud, max_f)
      `CHK(target, max_f)
      u_sw.set_term(11'h003, 1'b1); settle(); v = ud;
      repeat (10 * TD) @(negedge mclk_i);
      `CHK(ud, v)
      u_sw.set_term(11'h001, 1'b0);
      repeat (6 * TD) @(negedge mclk_i);
      u_sw.set_term(11'h002, 1'b0); settle(); v = ud;
      `CHK(v < max_f, 1'b1)
      repeat (10 * TD) @(negedge mclk_i);
      `CHK(ud, v)
      u_sw.set_term(11'h002, 1'b1); wait_ud(16'h0000);
      u_sw.set_term(11'h002, 1'b0);
      u_sw.set_term(11'h001, 1'b1);
      repeat (5 * TD) @(negedge mclk_i);
      u_sw.set_term(11'h001, 1'b0); settle(); v = ud;
      `CHK(v != 16'h0000, 1'b1)
      if (i == 0) trip = 1'b1; else pfail = 1'b1;
      @(negedge mclk_i); trip = 1'b0; pfail = 1'b0; settle();
      `CHK(saved, v)
      u_sw.set_key(FR, 1'b0); settle();
      `CHK(saved, v)
      u_sw.set_key(FR, 1'b1); settle();
      `CHK(ud, v)
      `CHK(target, v)
      u_sw.set_key(FR, 1'b0); settle();
      u_sw.set_term(11'h004, 1'b1); settle(); u_sw.set_term(11'h004, 1'b0);
      `CHK(saved, 16'h0000)
    end
    $display("test up down done");
    // Run enable on t3 under each stop option
    tfc = '0; ud_save = 1'b0; gated = 1'b1;
    u_sw.set_key(FR, 1'b1); settle();
    `CHK(run, 1'b1)
    tfc[18+:6] = FN_RUN_ENABLE; gated = 1'b0; settle();
    `CHK(run, 1'b1)
    gated = 1'b1;
    for (int opt = 0; opt < 3; opt++)
    begin
      stop_opt = 2'(opt);
      u_sw.set_term(11'h008, 1'b1); u_sw.set_key(FR, 1'b1); settle();
      `CHK(run, 1'b1)
      u_sw.set_term(11'h008, 1'b0); settle();
      `CHK(ramp == DRCL_RAMP_QSTOP, opt != 0)
      if (opt == 0) `CHK({coast, run}, 2'b10)
      u_sw.set_term(11'h008, 1'b1); settle();
      if (opt == 1) `CHK(run, 1'b0)
      if (opt == 2) `CHK(run, 1'b1)
      u_sw.set_key(FR, 1'b0); settle();
    end
    $display("test run enable done");
    // Three-wire latch on t4, then both directions at once
    tfc = '0; gated = 1'b0; tfc[24+:6] = FN_THREE_WIRE;
    u_sw.set_term(11'h010, 1'b1); settle();
    u_sw.pulse_key(FR); settle();
    `CHK(run, 1'b1)
    u_sw.pulse_term(11'h010); settle();
    `CHK(run, 1'b0)
    tfc = '0; u_sw.set_key(FR | RR, 1'b1); settle();
    `CHK(run, 1'b0)
    u_sw.set_key(FR | RR, 1'b0);
    $display("test three wire done");
    stop_test();
  end
endmodule : drcl_core_tb
`default_nettype wire
